// >>> logic/ssmrs_cfg.svh
`ifndef SSMRS_CFG_SVH
`define SSMRS_CFG_SVH

// ***************************************************************
// register offsets (byte addresses, one 32-bit word each)
// ***************************************************************
`define SSMRS_OFS_BAUD 8'h00
`define SSMRS_OFS_RXDATA 8'h04
`define SSMRS_OFS_RXSTAT 8'h08
`define SSMRS_OFS_DIVL 8'h0C
`define SSMRS_OFS_DIVH 8'h10
`define SSMRS_OFS_TXDATA 8'h14
`define SSMRS_OFS_TXSTAT 8'h18
`define SSMRS_OFS_IRQEN 8'h1C
`define SSMRS_OFS_FLAGS 8'h20

// ***************************************************************
// field positions
// ***************************************************************
`define SSMRS_B_RXIDLE 6
`define SSMRS_B_CKPOL 4
`define SSMRS_B_WIDEDIV 3
`define SSMRS_B_PORTEN 7
`define SSMRS_B_RX9SEL 6
`define SSMRS_B_SINGLE 5
`define SSMRS_B_CONT 4
`define SSMRS_B_OVERRUN 1
`define SSMRS_B_RX9BIT 0
`define SSMRS_B_CKMASTER 7
`define SSMRS_B_TX9SEL 6
`define SSMRS_B_TRANSMIT_ENABLE 5
`define SSMRS_B_SYNCSEL 4
`define SSMRS_B_HIRATE 2
`define SSMRS_B_TXIDLE 1
`define SSMRS_B_TX9BIT 0
`define SSMRS_B_RECEIVE_INTERRUPT_ENABLE 0
`define SSMRS_B_TRANSMIT_INTERRUPT_ENABLE 1
`define SSMRS_B_PERIPHERAL_INTERRUPT_ENABLE 2
`define SSMRS_B_GIE 3
`define SSMRS_B_RECEIVE_COMPLETE_FLAG 0
`define SSMRS_B_TRANSMIT_BUFFER_EMPTY_FLAG 1

// ***************************************************************
// reset values and counts
// ***************************************************************
`define SSMRS_BYTE_RST 8'h00
`define SSMRS_WORD_PAD 24'h00_0000
`define SSMRS_IEN_RST 4'h0
`define SSMRS_DIV_ZERO 16'h0000
`define SSMRS_DIV_ONE 16'h0001
`define SSMRS_LAST8 4'h7
`define SSMRS_LAST9 4'h8
`define SSMRS_CNT_ZERO 4'h0
`define SSMRS_CNT_ONE 4'h1
`define SSMRS_FIFO_FULL 2'h2
`define SSMRS_FIFO_EMPTY 2'h0

`endif

// >>> logic/ssmrs_pkg.sv
`default_nettype none
package ssmrs_pkg;

    // ***************************************************************
    // pin bundle, received character, receiver state
    // ***************************************************************
    typedef struct packed {
        logic ck;
        logic dt;
    } ssmrs_pin_t;

    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } ssmrs_char_t;

    typedef enum logic {
        RX_IDLE,
        RX_SHIFT
    } ssmrs_rx_st_t;

endpackage : ssmrs_pkg
`default_nettype wire

// >>> logic/ssmrs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ssmrs_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // levels
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // ***************************************************************
    // two-stage synchroniser
    // ***************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : ssmrs_sync
`default_nettype wire

// >>> logic/ssmrs_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssmrs_cfg.svh"
// Contract
// - master single or continuous receive on enable
// - receive flag set per character, interrupt enabled
// - ninth bit and overrun in status register
// - data read returns oldest character low byte
// - overrun cleared by continuous off or disable
// - slave when sync, not master, port enabled
// - slave transmits when both receive enables clear
// - second word waits, transmit flag stays clear
// - reload shifter and set transmit flag in one cycle
// - transmit flag wakes; global enable vectors
// - slave receive always continuous, single acts as continuous
// - slave receive works on external clock, wakes
// - slave takes external clock, own driver off
// - two-deep buffer, third sets overrun, stops
// - change on leading edge, sample trailing; polarity
module ssmrs_top (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // serial pins
    input wire ssmrs_pkg::ssmrs_pin_t pin_in,
    output var ssmrs_pkg::ssmrs_pin_t pin_out,
    output var ssmrs_pkg::ssmrs_pin_t pin_oe,
    // processor events
    output var logic wake_request,
    output var logic interrupt_request
);
    import ssmrs_pkg::*;

    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic clock_master_select_q, tx9_q, transmit_enable_q, sync_q, high_rate_select_q, transmit_ninth_bit_q;
    logic port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, clock_polarity_select_q, wide_divisor_select_q;
    logic [7:0] divl_q, divh_q;
    logic [3:0] ien_q;
    logic [15:0] div_w, brg_cnt_q;
    logic phase_q, ck_d_q, ovr_q;
    ssmrs_pin_t pin_s;
    ssmrs_rx_st_t rx_st_q;
    logic [3:0] rx_cnt_q, tx_cnt_q, rx_last, tx_last;
    logic [8:0] rsr_q, rx_word, tbuf_q, tsr_q;
    ssmrs_char_t fifo_q [2];
    ssmrs_char_t head;
    logic [1:0] fcnt_q;
    logic rp_q, tbuf_full_q, tx_busy_q, dt_q;
    logic [7:0] rd;
    logic hit;

    // ***************************************************************
    // decode and modes
    // ***************************************************************
    logic access, wr_done, rd_done, wr_rxstat, tx_wr;
    logic [7:0] wbyte;
    assign access = psel & penable;
    assign wr_done = access & pready & pwrite;
    assign rd_done = access & pready & ~pwrite;
    assign wbyte = pwdata[7:0];
    assign wr_rxstat = wr_done & (paddr == `SSMRS_OFS_RXSTAT);
    assign tx_wr = wr_done & (paddr == `SSMRS_OFS_TXDATA);

    logic master_mode, slave_mode, rx_on, rx_act, cont_rx, slave_tx;
    assign master_mode = port_enable_q & sync_q & clock_master_select_q;
    assign slave_mode = port_enable_q & sync_q & ~clock_master_select_q;
    assign rx_on = (master_mode | slave_mode) & (single_receive_enable_q | continuous_receive_enable_q);
    assign slave_tx = slave_mode & ~(single_receive_enable_q | continuous_receive_enable_q) & transmit_enable_q;
    assign rx_act = rx_on & ~ovr_q;
    assign cont_rx = continuous_receive_enable_q | slave_mode;

    // ***************************************************************
    // pin synchroniser and shift clock edges
    // ***************************************************************
    ssmrs_sync #(.W(2)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(pin_in),
        .q(pin_s)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ck_d_q <= 1'b0;
        end else begin
            ck_d_q <= pin_s.ck;
        end
    end

    // master clock generator, half period of divisor plus one
    assign div_w = wide_divisor_select_q ? {divh_q, divl_q} : {8'h00, divl_q};
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            brg_cnt_q <= `SSMRS_DIV_ZERO;
            phase_q <= 1'b0;
        end else if (!(master_mode && rx_act)) begin
            brg_cnt_q <= div_w;
            phase_q <= 1'b0;
        end else if (brg_cnt_q == `SSMRS_DIV_ZERO) begin
            brg_cnt_q <= div_w;
            phase_q <= ~phase_q;
        end else begin
            brg_cnt_q <= brg_cnt_q - `SSMRS_DIV_ONE;
        end
    end

    logic tick, lvl, lvl_d, lead, trail;
    assign tick = master_mode & rx_act & (brg_cnt_q == `SSMRS_DIV_ZERO);
    assign lvl = pin_s.ck ^ clock_polarity_select_q;
    assign lvl_d = ck_d_q ^ clock_polarity_select_q;
    assign lead = master_mode ? (tick & ~phase_q)
                              : (slave_mode & lvl & ~lvl_d);
    assign trail = master_mode ? (tick & phase_q)
                               : (slave_mode & ~lvl & lvl_d);

    // ***************************************************************
    // receive shifter
    // ***************************************************************
    assign rx_last = rx9_q ? `SSMRS_LAST9 : `SSMRS_LAST8;
    always_comb begin
        rx_word = rsr_q;
        rx_word[rx_cnt_q] = pin_s.dt;
        if (!rx9_q) begin
            rx_word[8] = 1'b0;
        end
    end

    logic rx_done, pop, push, ovf;
    assign rx_done = rx_act & trail & (rx_cnt_q == rx_last);
    assign pop = rd_done & (paddr == `SSMRS_OFS_RXDATA)
               & (fcnt_q != `SSMRS_FIFO_EMPTY);
    assign push = rx_done & ((fcnt_q != `SSMRS_FIFO_FULL) | pop);
    assign ovf = rx_done & ~push;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= `SSMRS_CNT_ZERO;
            rsr_q <= 9'h000;
        end else if (!rx_act) begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= `SSMRS_CNT_ZERO;
        end else if (trail) begin
            rsr_q <= rx_word;
            if (rx_cnt_q == rx_last) begin
                rx_st_q <= RX_IDLE;
                rx_cnt_q <= `SSMRS_CNT_ZERO;
            end else begin
                rx_st_q <= RX_SHIFT;
                rx_cnt_q <= rx_cnt_q + `SSMRS_CNT_ONE;
            end
        end else if (lead) begin
            rx_st_q <= RX_SHIFT;
        end
    end

    // ***************************************************************
    // two-entry receive buffer and overrun
    // ***************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
        end else if (push) begin
            fifo_q[rp_q ^ fcnt_q[0]] <= rx_word;
        end
    end
    assign head = fifo_q[rp_q];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fcnt_q <= `SSMRS_FIFO_EMPTY;
            rp_q <= 1'b0;
        end else if (!port_enable_q) begin
            fcnt_q <= `SSMRS_FIFO_EMPTY;
            rp_q <= 1'b0;
        end else begin
            if (pop) begin
                rp_q <= ~rp_q;
            end
            if (push && !pop) begin
                fcnt_q <= fcnt_q + 2'h1;
            end else if (pop && !push) begin
                fcnt_q <= fcnt_q - 2'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovr_q <= 1'b0;
        end else if (ovf) begin
            ovr_q <= 1'b1;
        end else if (!port_enable_q || (~cont_rx && pop)
                     || (wr_rxstat && continuous_receive_enable_q
                         && !wbyte[`SSMRS_B_CONT])) begin
            ovr_q <= 1'b0;
        end
    end

    // ***************************************************************
    // slave transmit buffer and shifter
    // ***************************************************************
    logic tx_move, tx_fin;
    assign tx_last = tx9_q ? `SSMRS_LAST9 : `SSMRS_LAST8;
    assign tx_move = tbuf_full_q & ~tx_busy_q & slave_tx;
    assign tx_fin = tx_busy_q & trail & (tx_cnt_q == tx_last);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tbuf_q <= 9'h000;
            tbuf_full_q <= 1'b0;
        end else if (!port_enable_q) begin
            tbuf_full_q <= 1'b0;
        end else if (tx_wr) begin
            tbuf_q <= {transmit_ninth_bit_q, wbyte};
            tbuf_full_q <= 1'b1;
        end else if (tx_move) begin
            tbuf_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tsr_q <= 9'h000;
            tx_busy_q <= 1'b0;
            tx_cnt_q <= `SSMRS_CNT_ZERO;
            dt_q <= 1'b0;
        end else if (!slave_tx) begin
            tx_busy_q <= 1'b0;
            tx_cnt_q <= `SSMRS_CNT_ZERO;
            dt_q <= 1'b0;
        end else if (tx_move) begin
            tsr_q <= tbuf_q;
            tx_busy_q <= 1'b1;
            tx_cnt_q <= `SSMRS_CNT_ZERO;
        end else if (tx_busy_q && lead) begin
            dt_q <= tsr_q[tx_cnt_q];
        end else if (tx_busy_q && trail) begin
            if (tx_fin) begin
                tx_busy_q <= 1'b0;
                tx_cnt_q <= `SSMRS_CNT_ZERO;
            end else begin
                tx_cnt_q <= tx_cnt_q + `SSMRS_CNT_ONE;
            end
        end
    end

    // ***************************************************************
    // control registers
    // ***************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {clock_master_select_q, tx9_q, transmit_enable_q, sync_q, high_rate_select_q, transmit_ninth_bit_q} <= 6'h00;
            {port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q} <= 4'h0;
            {clock_polarity_select_q, wide_divisor_select_q} <= 2'h0;
            divl_q <= `SSMRS_BYTE_RST;
            divh_q <= `SSMRS_BYTE_RST;
            ien_q <= `SSMRS_IEN_RST;
        end else begin
            if (rx_done && !cont_rx) begin
                single_receive_enable_q <= 1'b0;
            end
            if (wr_done) begin
                case (paddr)
                    `SSMRS_OFS_BAUD: begin
                        clock_polarity_select_q <= wbyte[`SSMRS_B_CKPOL];
                        wide_divisor_select_q <= wbyte[`SSMRS_B_WIDEDIV];
                    end
                    `SSMRS_OFS_RXSTAT: begin
                        port_enable_q <= wbyte[`SSMRS_B_PORTEN];
                        rx9_q <= wbyte[`SSMRS_B_RX9SEL];
                        single_receive_enable_q <= wbyte[`SSMRS_B_SINGLE];
                        continuous_receive_enable_q <= wbyte[`SSMRS_B_CONT];
                    end
                    `SSMRS_OFS_DIVL: divl_q <= wbyte;
                    `SSMRS_OFS_DIVH: divh_q <= wbyte;
                    `SSMRS_OFS_TXSTAT: begin
                        clock_master_select_q <= wbyte[`SSMRS_B_CKMASTER];
                        tx9_q <= wbyte[`SSMRS_B_TX9SEL];
                        transmit_enable_q <= wbyte[`SSMRS_B_TRANSMIT_ENABLE];
                        sync_q <= wbyte[`SSMRS_B_SYNCSEL];
                        high_rate_select_q <= wbyte[`SSMRS_B_HIRATE];
                        transmit_ninth_bit_q <= wbyte[`SSMRS_B_TX9BIT];
                    end
                    `SSMRS_OFS_IRQEN: ien_q <= wbyte[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ***************************************************************
    // read mux and apb answer
    // ***************************************************************
    logic receive_complete_flag, transmit_buffer_empty_flag;
    assign receive_complete_flag = fcnt_q != `SSMRS_FIFO_EMPTY;
    assign transmit_buffer_empty_flag = ~tbuf_full_q;

    always_comb begin
        rd = `SSMRS_BYTE_RST;
        hit = 1'b1;
        case (paddr)
            `SSMRS_OFS_BAUD: begin
                rd[`SSMRS_B_RXIDLE] = rx_st_q == RX_IDLE;
                rd[`SSMRS_B_CKPOL] = clock_polarity_select_q;
                rd[`SSMRS_B_WIDEDIV] = wide_divisor_select_q;
            end
            `SSMRS_OFS_RXDATA: rd = head.data;
            `SSMRS_OFS_RXSTAT: begin
                rd[`SSMRS_B_PORTEN] = port_enable_q;
                rd[`SSMRS_B_RX9SEL] = rx9_q;
                rd[`SSMRS_B_SINGLE] = single_receive_enable_q;
                rd[`SSMRS_B_CONT] = continuous_receive_enable_q;
                rd[`SSMRS_B_OVERRUN] = ovr_q;
                rd[`SSMRS_B_RX9BIT] = head.ninth;
            end
            `SSMRS_OFS_DIVL: rd = divl_q;
            `SSMRS_OFS_DIVH: rd = divh_q;
            `SSMRS_OFS_TXDATA: rd = `SSMRS_BYTE_RST;
            `SSMRS_OFS_TXSTAT: begin
                rd[`SSMRS_B_CKMASTER] = clock_master_select_q;
                rd[`SSMRS_B_TX9SEL] = tx9_q;
                rd[`SSMRS_B_TRANSMIT_ENABLE] = transmit_enable_q;
                rd[`SSMRS_B_SYNCSEL] = sync_q;
                rd[`SSMRS_B_HIRATE] = high_rate_select_q;
                rd[`SSMRS_B_TXIDLE] = ~tx_busy_q;
                rd[`SSMRS_B_TX9BIT] = transmit_ninth_bit_q;
            end
            `SSMRS_OFS_IRQEN: rd[3:0] = ien_q;
            `SSMRS_OFS_FLAGS: begin
                rd[`SSMRS_B_RECEIVE_COMPLETE_FLAG] = receive_complete_flag;
                rd[`SSMRS_B_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata <= {`SSMRS_WORD_PAD, rd};
            pready <= 1'b1;
            pslverr <= ~hit;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ***************************************************************
    // pins and processor events
    // ***************************************************************
    logic ev;
    assign ev = (receive_complete_flag & ien_q[`SSMRS_B_RECEIVE_INTERRUPT_ENABLE])
              | (transmit_buffer_empty_flag & ien_q[`SSMRS_B_TRANSMIT_INTERRUPT_ENABLE]);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= '0;
            pin_oe <= '0;
            wake_request <= 1'b0;
            interrupt_request <= 1'b0;
        end else begin
            pin_out.ck <= clock_polarity_select_q ^ phase_q;
            pin_out.dt <= dt_q;
            pin_oe.ck <= master_mode;
            pin_oe.dt <= slave_tx;
            wake_request <= ev & ien_q[`SSMRS_B_PERIPHERAL_INTERRUPT_ENABLE];
            interrupt_request <= ev & ien_q[`SSMRS_B_PERIPHERAL_INTERRUPT_ENABLE]
                               & ien_q[`SSMRS_B_GIE];
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    AST_SLAVE_CK_OFF: assert property (
        slave_mode |=> !pin_oe.ck)
        else $error("slave mode drives clock pin");
    AST_RX_FLAG: assert property (
        (rx_done && fcnt_q == 2'h0) |=> receive_complete_flag)
        else $error("receive flag missing after character");
    AST_OVR_KEEP: assert property (
        ovf |=> (ovr_q && fcnt_q == 2'h2 && $stable(rp_q)))
        else $error("overrun lost data or flag");
    AST_OVR_CLR: assert property (
        (wr_rxstat && continuous_receive_enable_q && !wbyte[4] && !ovf) |=> !ovr_q)
        else $error("overrun not cleared");
    AST_TX_MOVE: assert property (
        (tx_move && !tx_wr) |=> (transmit_buffer_empty_flag && tx_busy_q))
        else $error("transmit reload or flag wrong");
    AST_TX_HOLD: assert property (
        (port_enable_q && tx_busy_q && tbuf_full_q && !tx_fin) |=> !transmit_buffer_empty_flag)
        else $error("transmit flag set while word waits");
    AST_SINGLE_DONE: assert property (
        (master_mode && rx_done && !continuous_receive_enable_q && !wr_rxstat) |=> !single_receive_enable_q)
        else $error("single receive not ended");
    AST_WAKE: assert property (
        (ev && ien_q[2]) |=> (wake_request
            && interrupt_request == $past(ien_q[3])))
        else $error("wake or interrupt output wrong");
    AST_FLUSH: assert property (
        (wr_rxstat && !wbyte[7]) |=> ##1 (fcnt_q == 2'h0 && !tx_busy_q
            && rx_st_q == RX_IDLE))
        else $error("disable did not flush port");
    AST_APB_ACK: assert property (
        (access && !pready) |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule : ssmrs_top
`default_nettype wire

// >>> verification/ssmrs_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ssmrs_peer (
    // pins seen on the wire
    input wire logic dut_ck,
    input wire logic ck_oe,
    input wire logic dut_dt,
    // peer drive
    output var logic ck,
    output var logic dt
);
    // ***********************************************
    // serial peer, slave or master
    // ***********************************************
    logic [8:0] pat;
    int nbits;
    int idx;
    initial begin
        ck = 1'b0;
        dt = 1'b1;
        pat = 9'h000;
        nbits = 8;
        idx = 0;
    end
    // slave: bit on leading edge, lsb first
    always @(posedge dut_ck) begin
        if (ck_oe) begin
            dt <= pat[idx];
            idx <= (idx == nbits - 1) ? 0 : idx + 1;
        end
    end
    // master: one clock per bit, idle low
    task automatic frame(input logic [8:0] d, output logic [8:0] r);
        for (int i = 0; i < nbits; i++) begin
            ck = 1'b1;
            dt = d[i];
            #80;
            ck = 1'b0;
            r[i] = dut_dt;
            #80;
        end
        dt = ~dt;
    endtask : frame
endmodule : ssmrs_peer
`default_nettype wire

// >>> verification/sync_serial_master_rx_slave_txrx_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssmrs_cfg.svh"
module sync_serial_master_rx_slave_txrx_tb;
    import ssmrs_pkg::*;
    // ***********************************************
    // bench signals
    // ***********************************************
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, errv;
    logic wake_request, interrupt_request, peer_ck, peer_dt;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [8:0] got;
    ssmrs_pin_t pin_in, pin_out, pin_oe;
    wire logic ck_w;
    wire logic dt_w;
    int mismatches, check_count;
    typedef struct {
        logic [7:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
        logic err;
    } ssmrs_row_t;
    ssmrs_row_t rows [8] = '{
        '{`SSMRS_OFS_BAUD, 32'h0000_0008, 32'h0000_0048, 1'b0},
        '{`SSMRS_OFS_DIVL, 32'h0000_0009, 32'h0000_0009, 1'b0},
        '{`SSMRS_OFS_DIVH, 32'h0000_005A, 32'h0000_005A, 1'b0},
        '{`SSMRS_OFS_DIVH, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{`SSMRS_OFS_IRQEN, 32'h0000_0005, 32'h0000_0005, 1'b0},
        '{`SSMRS_OFS_FLAGS, 32'h0000_00FF, 32'h0000_0002, 1'b0},
        '{8'h24, 32'h0000_00FF, 32'h0000_0000, 1'b1},
        '{`SSMRS_OFS_TXSTAT, 32'h0000_0090, 32'h0000_0092, 1'b0}};
    assign ck_w = pin_oe.ck ? pin_out.ck : peer_ck;
    assign dt_w = pin_oe.dt ? pin_out.dt : peer_dt;
    assign pin_in = {ck_w, dt_w};
    ssmrs_top i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .wake_request(wake_request), .interrupt_request(interrupt_request));
    ssmrs_peer i_peer (.dut_ck(ck_w), .ck_oe(pin_oe.ck), .dut_dt(dt_w),
        .ck(peer_ck), .dt(peer_dt));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(rdv, e);
    endtask : rd
    task automatic poll(input logic [7:0] a, input logic [31:0] m);
        do begin
            apb(1'b0, a, 32'h0000_0000);
        end while ((rdv & m) === 32'h0000_0000);
    endtask : poll
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        #200000;
        mismatches++;
        complete_run;
    end
    // ***********************************************
    // test sequence
    // ***********************************************
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        mismatches = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].wd);
            check({31'h0, errv}, {31'h0, rows[i].err});
            rd(rows[i].a, rows[i].exp);
        end
        $display("register table done");
        rd(`SSMRS_OFS_RXSTAT, 32'h0000_0000);
        i_peer.pat = 9'h1A5;
        i_peer.nbits = 9;
        apb(1'b1, `SSMRS_OFS_RXSTAT, 32'h0000_00E0);
        poll(`SSMRS_OFS_FLAGS, 32'h0000_0001);
        check({30'h0, wake_request, interrupt_request}, 32'h2);
        rd(`SSMRS_OFS_RXSTAT, 32'h0000_00C1);
        rd(`SSMRS_OFS_RXDATA, 32'h0000_00A5);
        rd(`SSMRS_OFS_FLAGS, 32'h0000_0002);
        $display("master single receive done");
        i_peer.nbits = 8;
        i_peer.pat = 9'h0C3;
        i_peer.idx = 0;
        apb(1'b1, `SSMRS_OFS_RXSTAT, 32'h0000_0090);
        poll(`SSMRS_OFS_RXSTAT, 32'h0000_0002);
        rd(`SSMRS_OFS_RXSTAT, 32'h0000_0092);
        rd(`SSMRS_OFS_RXDATA, 32'h0000_00C3);
        apb(1'b1, `SSMRS_OFS_RXSTAT, 32'h0000_0000);
        rd(`SSMRS_OFS_RXSTAT, 32'h0000_0000);
        rd(`SSMRS_OFS_FLAGS, 32'h0000_0002);
        $display("overrun and disable done");
        apb(1'b1, `SSMRS_OFS_TXSTAT, 32'h0000_0030);
        apb(1'b1, `SSMRS_OFS_RXSTAT, 32'h0000_0080);
        apb(1'b1, `SSMRS_OFS_IRQEN, 32'h0000_000E);
        apb(1'b1, `SSMRS_OFS_TXDATA, 32'h0000_003C);
        apb(1'b1, `SSMRS_OFS_TXDATA, 32'h0000_00C3);
        rd(`SSMRS_OFS_FLAGS, 32'h0000_0000);
        check({30'h0, wake_request, interrupt_request}, 32'h0);
        check({30'h0, pin_oe.ck, pin_oe.dt}, 32'h1);
        i_peer.frame(9'h000, got);
        check({24'h0, got[7:0]}, 32'h0000_003C);
        rd(`SSMRS_OFS_FLAGS, 32'h0000_0002);
        check({30'h0, wake_request, interrupt_request}, 32'h3);
        i_peer.frame(9'h000, got);
        check({24'h0, got[7:0]}, 32'h0000_00C3);
        $display("slave transmit done");
        apb(1'b1, `SSMRS_OFS_IRQEN, 32'h0000_0005);
        apb(1'b1, `SSMRS_OFS_RXSTAT, 32'h0000_00B0);
        i_peer.frame(9'h05A, got);
        poll(`SSMRS_OFS_FLAGS, 32'h0000_0001);
        check({30'h0, wake_request, interrupt_request}, 32'h2);
        rd(`SSMRS_OFS_RXSTAT, 32'h0000_00B0);
        rd(`SSMRS_OFS_RXDATA, 32'h0000_005A);
        $display("slave receive done");
        complete_run;
    end
endmodule : sync_serial_master_rx_slave_txrx_tb
`default_nettype wire
